// ### hw/uaxm_pkg.sv
//==========================================================================
package uaxm_pkg;
  // register addresses
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_IEN  = 3'h1;
  localparam logic [2:0] ADR_ISTS = 3'h2;
  localparam logic [2:0] ADR_LCTL = 3'h3;
  localparam logic [2:0] ADR_MCTL = 3'h4;
  localparam logic [2:0] ADR_LSTS = 3'h5;
  localparam logic [2:0] ADR_MSTS = 3'h6;
  localparam logic [2:0] ADR_SCR  = 3'h7;
  // field positions
  localparam int BIT_DIV_ACC  = 7;
  localparam int BIT_SLEEP_EN = 4;
  localparam int BIT_LOOP     = 4;
  localparam int BIT_IR_EN    = 6;
  localparam int BIT_DTR      = 0;
  localparam int BIT_RTS      = 1;
  localparam int BIT_FC_IRINV = 2;
  localparam int BIT_FC_HDX   = 3;
  localparam int BIT_FC_SEL7  = 6;
  // values
  localparam logic [7:0] LCTL_ENH    = 8'hBF;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_ISTS    = 8'h01;
  localparam logic [7:0] RST_LSTS    = 8'h60;
  // identification codes, values arbitrary
  localparam logic [7:0] REV_CODE    = 8'h5A;
  localparam logic [7:0] ID_CODE     = 8'hA5;
  // bit timing: 16 ticks a bit, pulse 3 ticks
  localparam int TICKS_BIT   = 16;
  localparam int TICKS_PULSE = 3;
  localparam logic [15:0] DIV_DEFAULT = 16'h0001;
endpackage

// ### hw/uaxm_fifo.sv
`timescale 1ns/1ps
//==========================================================================
// fifo with valid/ready on both sides
module uaxm_fifo
  import uaxm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // honest full and empty from the level count
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and level
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_no_overfill: assert property (@(posedge clk_sys) disable iff (!rst_n)
    level <= (AW+1)'(DEPTH))
    else $error("fifo level beyond depth");
endmodule

// ### hw/uaxm_irda.sv
`timescale 1ns/1ps
//==========================================================================
// infrared pulse encoder and decoder, timed by a 16x bit tick
module uaxm_irda
  import uaxm_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // control
  input  wire logic ir_en,
  input  wire logic rx_invert,
  input  wire logic tick,
  input  wire logic bit_start,
  // serial data
  input  wire logic tx_nrz,
  output logic      tx_ir,
  input  wire logic rx_pin,
  output logic      rx_nrz
);
  logic [3:0] pulse_cnt;
  logic       rx_pol;

  // pulse counter restarts at every bit boundary of a zero bit
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pulse_cnt <= 4'h0;
    else if (bit_start && !tx_nrz)
      pulse_cnt <= 4'(TICKS_PULSE);
    else if (tick && pulse_cnt != 4'h0)
      pulse_cnt <= pulse_cnt - 4'h1;
  end

  // zero bit gives a 3/16 pulse, ones and idle stay low
  assign tx_ir = ir_en && (pulse_cnt != 4'h0);

  // optional polarity flip before decode
  assign rx_pol = rx_pin ^ rx_invert;
  // a light pulse is a logic one in the bit stream; plain line otherwise
  assign rx_nrz = ir_en ? rx_pol : rx_pin;
endmodule

// ### hw/uaxm_channel.sv
`timescale 1ns/1ps
//==========================================================================
// one uart channel: register decode, half duplex, infrared, loopback, sleep
module uaxm_channel
  import uaxm_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // host register port
  input  wire logic       cs_n,
  input  wire logic       channel_select,
  input  wire logic       chan_id,
  input  wire logic [2:0] addr,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata,
  output logic            rdata_oe,
  // serial and modem pins
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            rts_n,
  output logic            dtr_n,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       carrier_detect_n,
  input  wire logic       ring_indicator_n,
  // sleep
  input  wire logic       other_ready,
  output logic            sleep_ready,
  output logic            osc_out
);
  //========================================================================
  // input synchronisers
  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync1 <= 6'h3F;
      sync2 <= 6'h3F;
    end
    else
    begin
      sync1 <= {cs_n, wr_n, rd_n, rx_pin, channel_select, 1'b1};
      sync2 <= sync1;
    end
  end
  logic [3:0] m1;
  logic [3:0] m2;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      m1 <= 4'hF;
      m2 <= 4'hF;
    end
    else
    begin
      m1 <= {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
      m2 <= m1;
    end
  end
  logic sel;
  logic wr_s;
  logic rd_s;
  logic rx_s;
  logic wr_d;
  logic rd_d;
  assign sel  = !sync2[5] && (sync2[1] == chan_id);
  assign wr_s = sel && !sync2[4];
  assign rd_s = sel && !sync2[3];
  assign rx_s = sync2[2];
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_d <= 1'b0;
      rd_d <= 1'b0;
    end
    else
    begin
      wr_d <= wr_s;
      rd_d <= rd_s;
    end
  end
  logic wr_stb;
  logic rd_end;
  assign wr_stb = wr_s && !wr_d;
  assign rd_end = rd_d && !rd_s;

  //========================================================================
  // registers
  logic [7:0] lctl, ien, mctl, fctl, efn, afn, scr, fifo_trigger_level, emsel, div_lo;
  logic [7:0] div_hi;
  logic [7:0] xc [4];
  logic [7:0] receive_holding;
  logic [3:0] delta;
  logic       enh, dacc, dzero;
  assign enh   = (lctl == LCTL_ENH);
  assign dacc  = lctl[BIT_DIV_ACC] && !enh;
  assign dzero = (div_lo == RST_ZERO) && (div_hi == RST_ZERO);

  // write decode by line-control mode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lctl <= RST_ZERO; ien <= RST_ZERO; mctl <= RST_ZERO;
      fctl <= RST_ZERO; efn <= RST_ZERO; afn <= RST_ZERO;
      scr <= RST_ZERO; fifo_trigger_level <= RST_ZERO; emsel <= RST_ZERO;
      div_lo <= DIV_DEFAULT[7:0]; div_hi <= DIV_DEFAULT[15:8];
      for (int i = 0; i < 4; i++)
        xc[i] <= RST_ZERO;
    end
    else if (wr_stb)
    begin
      if (addr == ADR_LCTL)
        lctl <= wdata;
      else if (addr == ADR_MCTL && !enh)
        mctl <= wdata;
      else if (enh)
      begin
        case (addr)
          ADR_DATA: fifo_trigger_level <= wdata;
          ADR_IEN:  fctl <= wdata;
          ADR_ISTS: efn <= wdata;
          ADR_MCTL, ADR_LSTS, ADR_MSTS, ADR_SCR:
            xc[addr[1:0]] <= wdata;
          default:  ;
        endcase
      end
      else if (dacc)
      begin
        case (addr)
          ADR_DATA: div_lo <= wdata;
          ADR_IEN:  div_hi <= wdata;
          ADR_ISTS: afn <= wdata;
          default:  ;
        endcase
      end
      else
      begin
        case (addr)
          ADR_IEN: ien <= wdata;
          ADR_SCR:
            if (fctl[BIT_FC_SEL7])
              emsel <= wdata;
            else
              scr <= wdata;
          default: ;
        endcase
      end
    end
  end

  //========================================================================
  // transmit path: fifo then shifter
  logic       tx_push, tx_ready, f_valid, f_pop;
  logic [7:0] f_data;
  logic [3:0] f_level;
  assign tx_push = wr_stb && !enh && !dacc && addr == ADR_DATA;
  uaxm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .in_valid (tx_push),
    .in_ready (tx_ready),
    .in_data  (wdata),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data (f_data),
    .level    (f_level)
  );

  // baud tick from the divisor, 16 ticks a bit; a count at or above a new
  // divisor reloads at once, so a zero divisor reloads every cycle and stalls the channel
  logic [15:0] bcnt;
  logic        tick;
  assign tick = (bcnt == 16'h0000);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || tick || bcnt >= {div_hi, div_lo})
      bcnt <= {div_hi, div_lo} - 16'h0001;
    else
      bcnt <= bcnt - 16'h0001;
  end

  // shifter: start, 8 data, stop
  logic [9:0] shreg;
  logic [3:0] bits_left, sub;
  logic       busy, bit_start, rts_hold;
  assign f_pop     = !busy && tick && !rts_hold;
  assign bit_start = tick && (sub == 4'h0) && busy;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      shreg <= 10'h3FF; bits_left <= 4'h0; sub <= 4'h0; busy <= 1'b0;
    end
    else if (f_pop && f_valid)
    begin
      shreg <= {1'b1, f_data, 1'b0}; bits_left <= 4'hA; sub <= 4'h0;
      busy <= 1'b1;
    end
    else if (tick && busy)
    begin
      sub <= sub + 4'h1;
      if (sub == 4'(TICKS_BIT-1))
      begin
        shreg <= {1'b1, shreg[9:1]};
        bits_left <= bits_left - 4'h1;
        busy <= (bits_left != 4'h1);
      end
    end
  end

  // half duplex: low one tick before start, high when all drained
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rts_hold <= 1'b0;
    else if (!fctl[BIT_FC_HDX])
      rts_hold <= 1'b0;
    else if (f_valid && rts_hold)
      rts_hold <= 1'b0;
    else if (!f_valid && !busy && tick)
      rts_hold <= 1'b1;
  end
  logic hdx_high;
  assign hdx_high = fctl[BIT_FC_HDX] && !f_valid && !busy;

  //========================================================================
  // infrared coding and loopback
  logic loop, tx_code, rx_dec, rx_int;
  assign loop = mctl[BIT_LOOP];
  uaxm_irda u_ir (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ir_en    (mctl[BIT_IR_EN]),
    .rx_invert(fctl[BIT_FC_IRINV]),
    .tick     (tick),
    .bit_start(bit_start && sub == 4'h0),
    .tx_nrz   (shreg[0]),
    .tx_ir    (tx_code),
    .rx_pin   (rx_s),
    .rx_nrz   (rx_dec)
  );
  assign rx_int = loop ? shreg[0] : rx_dec;
  always_comb
  begin
    if (loop)
      tx_pin = 1'b1;
    else if (mctl[BIT_IR_EN])
      tx_pin = tx_code;
    else
      tx_pin = shreg[0];
  end
  // direction control owns the pin while enabled outside loopback, whatever the rts bit
  assign rts_n = loop ? 1'b1
               : fctl[BIT_FC_HDX] ? hdx_high : !mctl[BIT_RTS];
  assign dtr_n = loop ? 1'b1 : !mctl[BIT_DTR];

  // receive holding: last byte sampled mid bit on the internal line
  logic [7:0] rsh;
  logic       rdy;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rsh <= RST_ZERO;
    else if (tick && sub == 4'h7)
      rsh <= {rx_int, rsh[7:1]};
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      receive_holding <= RST_ZERO; rdy <= 1'b0;
    end
    // taken at the end of the last data bit, before the stop bit shifts in
    else if (tick && busy && bits_left == 4'h2 && sub == 4'hF)
    begin
      receive_holding <= rsh; rdy <= 1'b1;
    end
    else if (rd_end && addr == ADR_DATA && !enh && !lctl[BIT_DIV_ACC])
      rdy <= 1'b0;
  end

  //========================================================================
  // modem change flags: set wins over the read clear
  logic [3:0] m_prev, m_eff, chg;
  assign m_eff = loop ? 4'hF : m2;
  assign chg   = m_eff ^ m_prev;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      m_prev <= 4'hF;
    else
      m_prev <= m_eff;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      delta <= 4'h0;
    else if (rd_end && addr == ADR_MSTS && !enh)
      delta <= chg;
    else
      delta <= delta | chg;
  end

  //========================================================================
  // interrupt pending and sleep
  logic pend;
  logic [7:0] ists;
  assign pend = (ien[0] && rdy) || (ien[3] && delta != 4'h0);
  assign ists = pend ? {5'h00, ien[0] && rdy, 2'b00} : RST_ISTS;
  logic rx_prev, asleep;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rx_prev <= 1'b1;
    else
      rx_prev <= rx_s;
  end
  assign sleep_ready = ien[BIT_SLEEP_EN] && !pend && delta == 4'h0 && rx_s
                       && !f_valid && !busy;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      asleep <= 1'b0;
    else if ((rx_prev && !rx_s) || tx_push || chg != 4'h0)
      asleep <= 1'b0;
    else
      asleep <= sleep_ready && other_ready;
  end
  // oscillator output held quiet while asleep
  assign osc_out = !asleep && clk_sys;

  //========================================================================
  // read mux
  always_comb
  begin
    rdata = RST_ZERO;
    if (enh)
    begin
      case (addr)
        ADR_DATA: rdata = {4'h0, f_level};
        ADR_IEN:  rdata = fctl;
        ADR_ISTS: rdata = efn;
        ADR_LCTL: rdata = lctl;
        ADR_MCTL, ADR_LSTS, ADR_MSTS, ADR_SCR: rdata = xc[addr[1:0]];
        default:  rdata = RST_ZERO;
      endcase
    end
    else
    begin
      case (addr)
        ADR_DATA: rdata = dacc ? (dzero ? REV_CODE : div_lo) : receive_holding;
        ADR_IEN:  rdata = dacc ? (dzero ? ID_CODE : div_hi) : ien;
        ADR_ISTS: rdata = dacc ? afn : ists;
        ADR_LCTL: rdata = lctl;
        ADR_MCTL: rdata = mctl;
        ADR_LSTS: rdata = {1'b0, !f_valid && !busy, !f_valid, 4'h0, rdy};
        ADR_MSTS: rdata = {~m_eff, delta};
        ADR_SCR:  rdata = fctl[BIT_FC_SEL7] ? {4'h0, f_level} : scr;
        default:  rdata = RST_ZERO;
      endcase
    end
  end
  assign rdata_oe = rd_s;

  chk_loop_mark: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    loop |-> tx_pin && rts_n && dtr_n)
    else $error("loopback pins not idle");
  chk_sleep_pend: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pend |=> !asleep)
    else $error("slept with interrupt pending");
  chk_msr_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rd_end && addr == ADR_MSTS && !enh && chg == 4'h0) |=> delta == 4'h0)
    else $error("modem deltas not cleared");
  chk_ir_idle: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (mctl[BIT_IR_EN] && !loop && !busy) |-> !tx_pin)
    else $error("infrared idle not low");
  chk_hdx_busy: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (fctl[BIT_FC_HDX] && !loop && busy) |-> !rts_n)
    else $error("direction released mid character");
  // start edge on the receive line, one of the wake events
  sequence s_rx_fall;
    rx_prev && !rx_s;
  endsequence
  chk_wake_rx: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_rx_fall |=> !asleep)
    else $error("start edge did not wake");
endmodule

// ### sim/uaxm_line_model.sv
`timescale 1ns/1ps
//==========================================================================
// far-side line driver: mark idle, framed bytes sent lsb first
module uaxm_line_model
#(
  parameter int BIT_CYCLES = 16
)(
  // clock
  input  wire logic clk_sys,
  // serial line toward the channel
  output logic      rx_pin
);
  // idles at mark, as a pulled-up input would; only send_byte takes it low
  initial rx_pin = 1'b1;

  // start bit, eight data bits, one stop bit back at mark
  task automatic send_byte(input logic [7:0] b);
    int i;
    @(posedge clk_sys);
    #1 rx_pin = 1'b0;
    for (i = 0; i < 9; i++)
    begin
      repeat (BIT_CYCLES) @(posedge clk_sys);
      #1 rx_pin = (i < 8) ? b[i] : 1'b1;
    end
    repeat (BIT_CYCLES) @(posedge clk_sys);
  endtask
endmodule

// ### sim/test_uaxm_channel.sv
`timescale 1ns/1ps
//==========================================================================
// bench: register map, loopback, infrared, half duplex, sleep and wake
module test_uaxm_channel
  import uaxm_pkg::*;
();
  // clock, reset, host port
  logic       clk_sys;
  logic       rst_n;
  logic       cs_n;
  logic       channel_select;
  logic [2:0] addr;
  logic       wr_n;
  logic       rd_n;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rdata_oe;
  // serial, modem and sleep pins
  logic       rx_pin;
  logic       tx_pin;
  logic       rts_n;
  logic       dtr_n;
  logic [3:0] modem_n;
  logic       other_ready;
  logic       sleep_ready;
  logic       osc_out;
  // bookkeeping
  int         n_fail;
  int         n_checks;
  int         osc_n = 0;

  uaxm_channel #(.FIFO_DEPTH(8)) u_uaxm_channel (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .cs_n             (cs_n),
    .channel_select   (channel_select),
    .chan_id          (1'b0),
    .addr             (addr),
    .wr_n             (wr_n),
    .rd_n             (rd_n),
    .wdata            (wdata),
    .rdata            (rdata),
    .rdata_oe         (rdata_oe),
    .rx_pin           (rx_pin),
    .tx_pin           (tx_pin),
    .rts_n            (rts_n),
    .dtr_n            (dtr_n),
    .cts_n            (modem_n[0]),
    .dsr_n            (modem_n[1]),
    .carrier_detect_n (modem_n[2]),
    .ring_indicator_n (modem_n[3]),
    .other_ready      (other_ready),
    .sleep_ready      (sleep_ready),
    .osc_out          (osc_out)
  );

  uaxm_line_model #(.BIT_CYCLES(TICKS_BIT)) u_uaxm_line_model (
    .clk_sys (clk_sys),
    .rx_pin  (rx_pin)
  );

  // free-running clock; osc edges counted to see the oscillator stop
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge osc_out) osc_n++;

  //========================================================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // write strobe held 4 cycles, 3 idle after: above the sync minimum
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 {cs_n, addr, wdata, wr_n} = {1'b0, a, d, 1'b0};
    repeat (4) @(posedge clk_sys);
    #1 {cs_n, wr_n} = 2'b11;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 {cs_n, addr, rd_n} = {1'b0, a, 1'b0};
    repeat (4) @(posedge clk_sys);
    #1 d = rdata;
    check("read_enable", rdata_oe, channel_select ? 8'h00 : 8'h01);
    {cs_n, rd_n} = 2'b11;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp,
                      input string what);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  // bounded wait on one output; running out ends the run
  task automatic wait_for(input int sel, input logic lvl, input int bound,
                          input string what);
    int   i;
    logic v;
    for (i = 0; i < bound; i++)
    begin
      @(posedge clk_sys);
      #1 v = (sel == 0) ? sleep_ready : (sel == 1) ? tx_pin : rts_n;
      if (v === lvl)
        break;
    end
    check(what, (i < bound), 8'h01);
    if (i >= bound)
      tally_and_finish();
  endtask

  //========================================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] d;
    check("tx_reset", tx_pin, 8'h01);
    rchk(ADR_ISTS, RST_ISTS, "int_status");
    rchk(ADR_LSTS, RST_LSTS, "line_status");
    wr(ADR_LCTL, 8'h80);
    wr(ADR_DATA, 8'h00);
    wr(ADR_IEN, 8'h00);
    rchk(ADR_DATA, REV_CODE, "revision");
    rchk(ADR_IEN, ID_CODE, "ident");
    wr(ADR_ISTS, 8'h5C);
    rchk(ADR_ISTS, 8'h5C, "alt_func");
    wr(ADR_DATA, 8'h34);
    rchk(ADR_DATA, 8'h34, "div_low");
    wr(ADR_DATA, DIV_DEFAULT[7:0]);
    wr(ADR_IEN, DIV_DEFAULT[15:8]);
    wr(ADR_LCTL, LCTL_ENH);
    wr(ADR_IEN, 8'h40);
    rchk(ADR_IEN, 8'h40, "feature");
    wr(ADR_DATA, 8'hC0);
    rchk(ADR_DATA, 8'h00, "fifo_count");
    wr(ADR_MCTL, 8'h3C);
    rchk(ADR_MCTL, 8'h3C, "flow_one");
    wr(ADR_LCTL, 8'h03);
    wr(ADR_SCR, 8'h77);
    rchk(ADR_SCR, 8'h00, "level_count");
    wr(ADR_LCTL, LCTL_ENH);
    wr(ADR_IEN, 8'h00);
    wr(ADR_LCTL, 8'h03);
    wr(ADR_SCR, 8'h96);
    rchk(ADR_SCR, 8'h96, "scratch");
    // other channel: no enable on the bus and no write landing here
    #1 channel_select = 1'b1;
    rd(ADR_SCR, d);
    wr(ADR_SCR, 8'h11);
    #1 channel_select = 1'b0;
    rchk(ADR_SCR, 8'h96, "other_chan");
    $display("test regs done, fails %0d", n_fail);
  endtask

  task automatic t_loop();
    logic [7:0] d;
    int         i;
    wr(ADR_MCTL, 8'h03);
    check("rts_on", rts_n, 8'h00);
    wr(ADR_MCTL, 8'h13);
    check("loop_pins", {tx_pin, rts_n, dtr_n}, 8'h07);
    rd(ADR_MSTS, d);
    #1 modem_n = 4'h0;
    repeat (10) @(posedge clk_sys);
    rd(ADR_MSTS, d);
    check("loop_modem_in", d, 8'h00);
    #1 modem_n = 4'hF;
    wr(ADR_DATA, 8'h5A);
    for (i = 0; i < 400; i++)
    begin
      rd(ADR_LSTS, d);
      check("loop_tx_mark", tx_pin, 8'h01);
      if (d[0])
        break;
    end
    rchk(ADR_DATA, 8'h5A, "loop_echo");
    wr(ADR_MCTL, 8'h00);
    rd(ADR_MSTS, d);
    $display("test loopback done, fails %0d", n_fail);
  endtask

  task automatic ir_watch();
    int   c;
    int   r1;
    int   r2;
    int   width;
    int   pulses;
    logic last;
    {last, pulses, r1, r2, width} = '0;
    for (c = 0; c < 4000; c++)
    begin
      @(posedge clk_sys);
      #1;
      if (tx_pin === 1'b1 && last === 1'b0)
      begin
        pulses++;
        if (pulses == 1) r1 = c;
        if (pulses == 2) r2 = c;
      end
      if (tx_pin === 1'b1 && pulses == 1) width++;
      last = tx_pin;
    end
    check("ir_pulses", 8'(pulses), 8'h09);
    check("ir_width", 8'(width * 16 == (r2 - r1) * 3), 8'h01);
  endtask

  task automatic t_infrared();
    wr(ADR_MCTL, 8'h40);
    check("ir_idle", tx_pin, 8'h00);
    fork
      wr(ADR_DATA, 8'h00);
      ir_watch();
    join
    wr(ADR_MCTL, 8'h00);
    check("nrz_idle", tx_pin, 8'h01);
    $display("test infrared done, fails %0d", n_fail);
  endtask

  task automatic t_halfdup();
    logic [7:0] d;
    wr(ADR_LCTL, LCTL_ENH);
    wr(ADR_IEN, 8'h08);
    wr(ADR_LCTL, 8'h03);
    wr(ADR_DATA, 8'h55);
    wr(ADR_DATA, 8'hAA);
    wr(ADR_DATA, 8'h0F);
    wait_for(1, 1'b0, 600, "hdx_start");
    check("rts_before_start", rts_n, 8'h00);
    wait_for(2, 1'b1, 9000, "hdx_release");
    check("tx_at_release", tx_pin, 8'h01);
    rd(ADR_LSTS, d);
    check("all_empty", d & 8'h40, 8'h40);
    wr(ADR_LCTL, LCTL_ENH);
    wr(ADR_IEN, 8'h00);
    wr(ADR_LCTL, 8'h03);
    $display("test half duplex done, fails %0d", n_fail);
  endtask

  task automatic t_sleep();
    logic [7:0] d;
    int         n;
    int         k;
    rd(ADR_MSTS, d);
    #1 other_ready = 1'b1;
    wr(ADR_IEN, 8'h10);
    wait_for(0, 1'b1, 300, "sleep_entry");
    // the gate closes one edge later; count only once it has settled
    repeat (2) @(posedge clk_sys);
    #1 n = osc_n;
    repeat (20) @(posedge clk_sys);
    check("osc_halted", 8'(osc_n - n), 8'h00);
    #1 other_ready = 1'b0;
    repeat (20) @(posedge clk_sys);
    check("osc_other_awake", 8'(osc_n != n), 8'h01);
    #1 other_ready = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      #1 modem_n[k] = 1'b0;
      wait_for(0, 1'b0, 20, "wake_modem");
      repeat (40) @(posedge clk_sys);
      check("awake_until_read", sleep_ready, 8'h00);
      rd(ADR_MSTS, d);
      wait_for(0, 1'b1, 300, "resleep");
      modem_n[k] = 1'b1;
      repeat (10) @(posedge clk_sys);
      rd(ADR_MSTS, d);
      wait_for(0, 1'b1, 300, "resleep_high");
    end
    fork
      wr(ADR_DATA, 8'h33);
      wait_for(0, 1'b0, 20, "wake_tx");
    join
    wait_for(0, 1'b1, 5000, "resleep_tx");
    fork
      u_uaxm_line_model.send_byte(8'hC3);
      wait_for(0, 1'b0, 20, "wake_rx");
    join
    rd(ADR_DATA, d);
    wait_for(0, 1'b1, 5000, "resleep_rx");
    wr(ADR_IEN, 8'h00);
    wait_for(0, 1'b0, 10, "sleep_off");
    repeat (50) @(posedge clk_sys);
    check("stays_awake", sleep_ready, 8'h00);
    $display("test sleep done, fails %0d", n_fail);
  endtask

  //========================================================================
  // main sequence
  initial
  begin
    {cs_n, wr_n, rd_n, channel_select, addr, wdata} = {3'b111, 12'h000};
    {modem_n, other_ready, rst_n, n_fail, n_checks} = '0;
    modem_n = 4'hF;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_loop();
    t_infrared();
    t_halfdup();
    t_sleep();
    tally_and_finish();
  end
endmodule
